// ==== hdl/mrsf_params.svh ====
// Purpose: timing counts, codes and field values for the rtu framer pair
// Assumes: 40 MHz system clock, default 1-8-N-1 at 9600 bps
// Notes: definitions only
`ifndef MRSF_PARAMS_SVH
`define MRSF_PARAMS_SVH

`define MRSF_CLK_HZ 40000000
`define MRSF_BAUD 9600
`define MRSF_CHAR_BITS 10
// least frame gap in tenths of a character
`define MRSF_GAP_X10 35
// bit period rounded down, error stays far below uart tolerance
`define MRSF_BIT_CYC (`MRSF_CLK_HZ / `MRSF_BAUD)
// least gap, rounded up to whole cycles
`define MRSF_GAP_CYC (((`MRSF_CLK_HZ / 10) * `MRSF_CHAR_BITS * `MRSF_GAP_X10 + \
    `MRSF_BAUD - 1) / `MRSF_BAUD)
`define MRSF_RESP_TMO_CYC 400000
`define MRSF_CRC_INIT 16'hffff
`define MRSF_CRC_POLY 16'ha001
`define MRSF_FC_READ 8'h03
`define MRSF_ERR_FLAG 8'h80
`define MRSF_BCAST 8'h00
`define MRSF_MAX_REGS 8'h0a
`define MRSF_EX_FC 8'h02
`define MRSF_EX_ADDR 8'h04
`define MRSF_EX_PARAM 8'h05
`define MRSF_FIFO_W 8
`define MRSF_FIFO_DEPTH 8

`endif

// ==== hdl/mrsf_pkg.sv ====
// Purpose: types and shared helpers of the rtu framer pair
// Assumes: mrsf_params.svh holds every number
// Notes: uart steppers are shared by both ends
`include "mrsf_params.svh"
package mrsf_pkg;

    typedef enum logic [2:0] {
        S_RX = 3'b000, S_RD = 3'b001, S_WAIT = 3'b010, S_TX = 3'b011, S_DRAIN = 3'b100
    } mrsf_dev_st_e;

    typedef enum logic [1:0] {
        M_IDLE = 2'b00, M_GAP = 2'b01, M_SEND = 2'b10, M_RESP = 2'b11
    } mrsf_mst_st_e;

    typedef struct packed {
        logic busy;
        logic done;
        logic err;
        logic [15:0] cnt;
        logic [3:0] bitn;
        logic [9:0] sh;
    } mrsf_uart_s;

    // modbus crc, reflected polynomial, lsb first
    function automatic logic [15:0] mrsf_crc(logic [15:0] c, logic [7:0] b);
        logic [15:0] x;
        x = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            x = x[0] ? ((x >> 1) ^ `MRSF_CRC_POLY) : (x >> 1);
        end
        return x;
    endfunction

    function automatic logic [23:0] mrsf_max(logic [23:0] a, logic [23:0] b);
        return (a > b) ? a : b;
    endfunction

    // receiver: start check at half bit, then samples at bit centres
    function automatic mrsf_uart_s mrsf_rx_step(mrsf_uart_s u, logic line, logic [15:0] bc);
        mrsf_uart_s n;
        n = u;
        n.done = 1'b0;
        n.err = 1'b0;
        if (!u.busy) begin
            if (!line) begin
                n.busy = 1'b1;
                n.cnt = {1'b0, bc[15:1]};
                n.bitn = 4'h0;
            end
        end else if (u.cnt != 16'h0) begin
            n.cnt = u.cnt - 16'h1;
        end else begin
            n.cnt = bc - 16'h1;
            n.bitn = u.bitn + 4'h1;
            if (u.bitn == 4'h0) begin
                n.busy = ~line; // a glitch is not a start bit
            end else if (u.bitn < 4'h9) begin
                n.sh[7:0] = {line, u.sh[7:1]};
            end else begin
                n.busy = 1'b0;
                n.done = line;
                n.err = ~line; // missing stop bit
            end
        end
        return n;
    endfunction

    // transmitter: start, 8 data lsb first, one stop, no parity
    function automatic mrsf_uart_s mrsf_tx_step(mrsf_uart_s u, logic load, logic [7:0] d,
                                                logic [15:0] bc);
        mrsf_uart_s n;
        n = u;
        n.done = 1'b0;
        if (!u.busy) begin
            if (load) begin
                n.busy = 1'b1;
                n.sh = {1'b1, d, 1'b0};
                n.cnt = bc - 16'h1;
                n.bitn = 4'h0;
            end
        end else if (u.cnt != 16'h0) begin
            n.cnt = u.cnt - 16'h1;
        end else if (u.bitn == 4'h9) begin
            n.busy = 1'b0;
            n.done = 1'b1;
        end else begin
            n.sh = {1'b1, u.sh[9:1]};
            n.bitn = u.bitn + 4'h1;
            n.cnt = bc - 16'h1;
        end
        return n;
    endfunction

endpackage

// ==== hdl/mrsf_link_if.sv ====
// Purpose: half-duplex rs485 segment between one master and one slave
// Assumes: each party drives its own data line with an enable
// Notes: each end reads the other's data line directly, the bench checks both data lines and both enables
`timescale 1ns/1ps
interface mrsf_link_if;
    logic m_txd; // master data, idle high
    logic m_de;  // master drives the pair
    logic s_txd; // slave data, idle high
    logic s_de;  // slave drives the pair
    modport master (output m_txd, output m_de, input s_txd, input s_de);
    modport slave (input m_txd, input m_de, output s_txd, output s_de);
endinterface

// ==== hdl/mrsf_fifo.sv ====
// Purpose: small flop fifo with valid/ready on both sides
// Assumes: depth is a power of two
// Notes: no bypass, a word spends at least one cycle inside
`timescale 1ns/1ps
`include "mrsf_params.svh"
module mrsf_fifo #(
    parameter int unsigned W = `MRSF_FIFO_W,
    parameter int unsigned D = `MRSF_FIFO_DEPTH
) (
    input wire logic clk_sys,          // system clock
    input wire logic rstn,             // sync reset, active low
    input wire logic in_valid,         // write offered
    input wire logic [W-1:0] in_data,  // write word
    output logic in_ready,             // not full
    output logic out_valid,            // not empty
    output logic [W-1:0] out_data,     // head word
    input wire logic out_ready         // reader takes head
);
    localparam int unsigned AW = $clog2(D);
    logic [W-1:0] mem_r [D];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign in_ready = (cnt_r != (AW+1)'(D));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];

    // pointers wrap by width since depth is a power of two
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wp_nxt = push ? wp_r + AW'(1) : wp_r;
        rp_nxt = pop ? rp_r + AW'(1) : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end
endmodule // mrsf_fifo

// ==== hdl/mrsf_slave.sv ====
// Purpose: slave end of a modbus rtu link, read command with exceptions
// Assumes: mrsf_pkg, mrsf_fifo, register contents fetched over rd_* handshake
// Notes: reply bytes pass an 8-word fifo in front of the uart transmitter
// Summary of operation
// - async half-duplex 1-8-N-1, 9600 default
// - broadcast request never gets a reply
// - multi-byte fields other than the crc go high byte first
// - frame bounded by 3.5 character idle
// - frame gap is max(setting, 3.5 chars)
// - one gap between frames is enough
// - crc-16 ends frame, low byte first
// - reply delay is max(setting, frame gap)
// - single master, one or many slaves
// - read request: addr, 03, start, count, crc
// - read reply: addr, 03, bytecount, data, crc
// - error reply: command+0x80 then exception code
// - register address high byte group, low index
`timescale 1ns/1ps
`include "mrsf_params.svh"
module mrsf_slave #(
    parameter int unsigned BIT_CYC = `MRSF_BIT_CYC, // cycles per bit
    parameter int unsigned GAP_CYC = `MRSF_GAP_CYC  // cycles in 3.5 chars
) (
    mrsf_link_if.slave bus,           // rs485 pair
    input wire logic clk_sys,         // system clock
    input wire logic rstn,            // sync reset, active low
    input wire logic [7:0] station_id, // own station number
    input wire logic [23:0] cfg_gap_cyc, // configured frame gap
    input wire logic [23:0] cfg_dly_cyc, // configured reply delay
    output logic rd_req,              // register fetch, held until rd_ack
    output logic [7:0] rd_group,      // parameter group
    output logic [7:0] rd_index,      // index within group
    input wire logic rd_ack,          // fetch answered
    input wire logic [15:0] rd_data,  // register content
    input wire logic rd_err,          // address not mapped
    output logic frm_ok,              // pulse: frame for us taken
    output logic crc_err              // pulse: frame dropped on crc or format
);
    typedef struct packed {
        mrsf_pkg::mrsf_dev_st_e fsm;
        logic [23:0] idle;
        mrsf_pkg::mrsf_uart_s rx;
        mrsf_pkg::mrsf_uart_s tx;
        logic [3:0] nb;
        logic fbad;
        logic [15:0] crc;
        logic [7:0][7:0] frm;
        logic [9:0][15:0] rdat;
        logic [4:0] ri;
        logic [7:0] exc;
        logic [15:0] rdaddr;
        logic rd_req;
        logic frm_ok;
        logic crc_err;
        logic txd;
        logic de;
    } mrsf_dev_s;

    mrsf_dev_s r, n;
    logic [23:0] gap_eff, dly_eff;
    logic [4:0] body;
    logic [15:0] word;
    logic [15:0] bc;
    logic f_valid, f_ready, q_valid, q_ready, clr;
    logic [7:0] f_data, q_data, fc, nreg;

    assign bus.s_txd = r.txd;
    assign bus.s_de = r.de;
    assign rd_req = r.rd_req;
    assign rd_group = r.rdaddr[15:8];
    assign rd_index = r.rdaddr[7:0];
    assign frm_ok = r.frm_ok;
    assign crc_err = r.crc_err;

    // reply bytes; the uart drains slower than the fsm fills, so it stalls here
    mrsf_fifo #(.W(`MRSF_FIFO_W), .D(`MRSF_FIFO_DEPTH)) u_txq (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .in_valid(f_valid),
        .in_data(f_data),
        .in_ready(f_ready),
        .out_valid(q_valid),
        .out_data(q_data),
        .out_ready(q_ready)
    );

    // frame parse, register fetch, reply build and both uarts
    always_comb begin
        n = r;
        n.frm_ok = 1'b0;
        n.crc_err = 1'b0;
        clr = 1'b0;
        f_valid = 1'b0;
        f_data = 8'h00;
        bc = 16'(BIT_CYC);
        gap_eff = mrsf_pkg::mrsf_max(cfg_gap_cyc, 24'(GAP_CYC));
        dly_eff = mrsf_pkg::mrsf_max(cfg_dly_cyc, 24'(GAP_CYC));
        fc = r.frm[1];
        nreg = r.frm[5];
        body = (r.exc != 8'h00) ? 5'h03 : 5'h03 + {nreg[3:0], 1'b0};
        word = r.rdat[4'((r.ri - 5'h03) >> 1)];
        q_ready = ~r.tx.busy;
        n.rx = mrsf_pkg::mrsf_rx_step(r.rx, bus.m_txd, bc);
        // idle time since the last character on either side
        n.idle = (r.rx.busy || r.de) ? 24'h000000 :
                 ((r.idle == 24'hffffff) ? r.idle : r.idle + 24'h000001);
        case (r.fsm)
            mrsf_pkg::S_RX: begin
                if (n.rx.err) begin
                    n.fbad = 1'b1;
                end
                if (n.rx.done) begin
                    if (r.nb < 4'h8) begin
                        n.frm[r.nb[2:0]] = n.rx.sh[7:0];
                    end
                    n.nb = (r.nb == 4'h9) ? r.nb : r.nb + 4'h1;
                    n.crc = mrsf_pkg::mrsf_crc(r.crc, n.rx.sh[7:0]);
                end else if (r.nb != 4'h0 && r.idle == gap_eff) begin
                    clr = 1'b1;
                    if (r.fbad || r.nb < 4'h4 || r.crc != 16'h0000) begin
                        n.crc_err = 1'b1; // silent drop
                    end else if (r.frm[0] == station_id || r.frm[0] == `MRSF_BCAST) begin
                        n.frm_ok = 1'b1;
                        if (r.frm[0] != `MRSF_BCAST) begin
                            clr = 1'b0;
                            n.fsm = mrsf_pkg::S_WAIT;
                            n.ri = 5'h00;
                            n.rdaddr = {r.frm[2], r.frm[3]};
                            if (fc != `MRSF_FC_READ) begin
                                n.exc = `MRSF_EX_FC;
                            end else if (r.nb != 4'h8 || r.frm[4] != 8'h00 ||
                                         nreg == 8'h00 || nreg > `MRSF_MAX_REGS) begin
                                n.exc = `MRSF_EX_PARAM;
                            end else begin
                                n.fsm = mrsf_pkg::S_RD;
                            end
                        end
                    end
                end
            end
            mrsf_pkg::S_RD: begin
                if (r.rd_req && rd_ack) begin
                    if (rd_err) begin
                        n.exc = `MRSF_EX_ADDR;
                        n.fsm = mrsf_pkg::S_WAIT;
                    end else begin
                        n.rdat[r.ri[3:0]] = rd_data;
                        n.rdaddr = r.rdaddr + 16'h0001;
                        n.ri = r.ri + 5'h01;
                        if (r.ri + 5'h01 == nreg[4:0]) begin
                            n.fsm = mrsf_pkg::S_WAIT;
                        end
                    end
                end
            end
            mrsf_pkg::S_WAIT: begin
                // idle counts from the request's last byte, so fetch time is absorbed
                if (r.idle >= dly_eff) begin
                    n.fsm = mrsf_pkg::S_TX;
                    n.ri = 5'h00;
                    n.crc = `MRSF_CRC_INIT;
                end
            end
            mrsf_pkg::S_TX: begin
                f_valid = 1'b1;
                if (r.ri == 5'h00) begin
                    f_data = r.frm[0];
                end else if (r.ri == 5'h01) begin
                    f_data = (r.exc != 8'h00) ? (fc | `MRSF_ERR_FLAG) : fc;
                end else if (r.ri == 5'h02) begin
                    f_data = (r.exc != 8'h00) ? r.exc : {nreg[6:0], 1'b0};
                end else if (r.ri == body) begin
                    f_data = r.crc[7:0];
                end else if (r.ri == body + 5'h01) begin
                    f_data = r.crc[15:8];
                end else begin
                    f_data = r.ri[0] ? word[15:8] : word[7:0];
                end
                if (f_ready) begin
                    n.ri = r.ri + 5'h01;
                    if (r.ri < body) begin
                        n.crc = mrsf_pkg::mrsf_crc(r.crc, f_data);
                    end
                    if (r.ri == body + 5'h01) begin
                        n.fsm = mrsf_pkg::S_DRAIN;
                    end
                end
            end
            mrsf_pkg::S_DRAIN: begin
                if (!q_valid && !r.tx.busy) begin
                    clr = 1'b1;
                end
            end
            default: begin
                clr = 1'b1;
            end
        endcase
        if (clr) begin
            n.fsm = mrsf_pkg::S_RX;
            n.nb = 4'h0;
            n.fbad = 1'b0;
            n.exc = 8'h00;
            n.crc = `MRSF_CRC_INIT;
        end
        // request held until answered, dropped for one cycle between fetches
        n.rd_req = (n.fsm == mrsf_pkg::S_RD) && !(r.rd_req && rd_ack);
        n.tx = mrsf_pkg::mrsf_tx_step(r.tx, q_valid, q_data, bc);
        n.txd = n.tx.busy ? n.tx.sh[0] : 1'b1;
        // driver stays on for the whole reply, so byte gaps never release the pair
        n.de = (n.fsm == mrsf_pkg::S_TX) || (n.fsm == mrsf_pkg::S_DRAIN);
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            r <= '0;
            r.txd <= 1'b1;
            r.crc <= `MRSF_CRC_INIT;
        end else begin
            r <= n;
        end
    end
endmodule // mrsf_slave

// ==== hdl/mrsf_master.sv ====
// Purpose: master end issuing read requests and collecting the reply
// Assumes: mrsf_pkg, one slave or many on the segment
// Notes: reply bytes are passed on raw, crc verdict comes with done
`timescale 1ns/1ps
`include "mrsf_params.svh"
module mrsf_master #(
    parameter int unsigned BIT_CYC = `MRSF_BIT_CYC,        // cycles per bit
    parameter int unsigned GAP_CYC = `MRSF_GAP_CYC,        // cycles in 3.5 chars
    parameter int unsigned TMO_CYC = `MRSF_RESP_TMO_CYC    // reply timeout
) (
    mrsf_link_if.master bus,         // rs485 pair
    input wire logic clk_sys,        // system clock
    input wire logic rstn,           // sync reset, active low
    input wire logic req_valid,      // pulse: start a read
    input wire logic [7:0] req_addr, // station, zero is broadcast
    input wire logic [15:0] req_reg, // start register
    input wire logic [15:0] req_cnt, // register count
    output logic busy,               // request in progress
    output logic [7:0] rx_byte,      // reply byte
    output logic rx_valid,           // pulse: rx_byte new
    output logic done,               // pulse: request finished
    output logic resp_ok,            // with done: reply crc good
    output logic resp_tmo            // with done: no reply
);
    typedef struct packed {
        mrsf_pkg::mrsf_mst_st_e fsm;
        logic [23:0] idle;
        mrsf_pkg::mrsf_uart_s rx;
        mrsf_pkg::mrsf_uart_s tx;
        logic [2:0] bi;
        logic [15:0] crc;
        logic [15:0] rcrc;
        logic rbad;
        logic got;
        logic [7:0] addr;
        logic [15:0] reg0;
        logic [15:0] cnt;
        logic [7:0] rx_byte;
        logic rx_v;
        logic done;
        logic ok;
        logic tmo;
        logic txd;
        logic de;
    } mrsf_mst_s;

    mrsf_mst_s r, n;
    logic [7:0] tb;
    logic load;
    logic [15:0] bc;

    assign bus.m_txd = r.txd;
    assign bus.m_de = r.de;
    assign busy = (r.fsm != mrsf_pkg::M_IDLE);
    assign rx_byte = r.rx_byte;
    assign rx_valid = r.rx_v;
    assign done = r.done;
    assign resp_ok = r.ok;
    assign resp_tmo = r.tmo;

    // request sequencer and both uarts
    always_comb begin
        n = r;
        n.rx_v = 1'b0;
        n.done = 1'b0;
        bc = 16'(BIT_CYC);
        case (r.bi)
            3'h0: tb = r.addr;
            3'h1: tb = `MRSF_FC_READ;
            3'h2: tb = r.reg0[15:8]; // high byte first
            3'h3: tb = r.reg0[7:0];
            3'h4: tb = r.cnt[15:8];
            3'h5: tb = r.cnt[7:0];
            3'h6: tb = r.crc[7:0];   // crc low byte first
            default: tb = r.crc[15:8];
        endcase
        load = (r.fsm == mrsf_pkg::M_SEND) && !r.tx.busy;
        n.rx = mrsf_pkg::mrsf_rx_step(r.rx, bus.s_txd, bc);
        n.idle = (r.rx.busy || r.de) ? 24'h000000 :
                 ((r.idle == 24'hffffff) ? r.idle : r.idle + 24'h000001);
        case (r.fsm)
            mrsf_pkg::M_IDLE: begin
                if (req_valid) begin
                    n.fsm = mrsf_pkg::M_GAP;
                    n.addr = req_addr;
                    n.reg0 = req_reg;
                    n.cnt = req_cnt;
                end
            end
            mrsf_pkg::M_GAP: begin
                // bus must have been quiet for a full frame gap first
                if (r.idle >= 24'(GAP_CYC)) begin
                    n.fsm = mrsf_pkg::M_SEND;
                    n.bi = 3'h0;
                    n.crc = `MRSF_CRC_INIT;
                    n.rcrc = `MRSF_CRC_INIT;
                    n.rbad = 1'b0;
                    n.got = 1'b0;
                end
            end
            mrsf_pkg::M_SEND: begin
                if (load) begin
                    n.bi = r.bi + 3'h1;
                    if (r.bi < 3'h6) begin
                        n.crc = mrsf_pkg::mrsf_crc(r.crc, tb);
                    end
                    if (r.bi == 3'h7) begin
                        n.fsm = mrsf_pkg::M_RESP;
                    end
                end
            end
            mrsf_pkg::M_RESP: begin
                if (n.rx.err) begin
                    n.rbad = 1'b1;
                end
                if (n.rx.done) begin
                    n.rx_byte = n.rx.sh[7:0];
                    n.rx_v = 1'b1;
                    n.got = 1'b1;
                    n.rcrc = mrsf_pkg::mrsf_crc(r.rcrc, n.rx.sh[7:0]);
                end else if (!r.tx.busy && (r.got || r.addr == `MRSF_BCAST) &&
                             r.idle == 24'(GAP_CYC)) begin
                    n.fsm = mrsf_pkg::M_IDLE;
                    n.done = 1'b1;
                    n.ok = r.got && !r.rbad && r.rcrc == 16'h0000;
                    n.tmo = 1'b0;
                end else if (!r.tx.busy && !r.got && r.idle == 24'(TMO_CYC)) begin
                    n.fsm = mrsf_pkg::M_IDLE;
                    n.done = 1'b1;
                    n.ok = 1'b0;
                    n.tmo = 1'b1;
                end
            end
            default: begin
                n.fsm = mrsf_pkg::M_IDLE;
            end
        endcase
        n.tx = mrsf_pkg::mrsf_tx_step(r.tx, load, tb, bc);
        n.txd = n.tx.busy ? n.tx.sh[0] : 1'b1;
        n.de = n.tx.busy || (n.fsm == mrsf_pkg::M_SEND);
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            r <= '0;
            r.txd <= 1'b1;
            r.crc <= `MRSF_CRC_INIT;
            r.rcrc <= `MRSF_CRC_INIT;
        end else begin
            r <= n;
        end
    end
endmodule // mrsf_master

// ==== testbench/mrsf_link_asserts.sv ====
// Purpose: line checks on the rtu master and slave pair
// Assumes: one clock, both lines idle high
// Notes: run counters saturate so a long idle never wraps
`timescale 1ns/1ps
module mrsf_link_asserts #(
    parameter int BIT_CYC = 16, // cycles per bit
    parameter int GAP_CYC = 600 // cycles in 3.5 chars
) (
    input wire logic clk_sys, // system clock
    input wire logic rstn,    // sync reset, active low
    input wire logic m_txd,   // master data
    input wire logic m_de,    // master enable
    input wire logic s_txd,   // slave data
    input wire logic s_de     // slave enable
);
    logic m_prev_r, s_prev_r;
    logic [15:0] m_run_r, s_run_r;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // cycles since each line last moved; full after reset so idle reads as long
    always_ff @(posedge clk_sys) begin
        m_prev_r <= m_txd;
        s_prev_r <= s_txd;
        m_run_r <= !rstn ? 16'hffff : (m_txd != m_prev_r) ? 16'h0000
            : m_run_r + {15'h0000, ~&m_run_r};
        s_run_r <= !rstn ? 16'hffff : (s_txd != s_prev_r) ? 16'h0000
            : s_run_r + {15'h0000, ~&s_run_r};
    end
    chk_half_duplex: assert property (!(m_de && s_de)) else $error("both ends drive");
    chk_slave_quiet: assert property (!s_txd |-> s_de) else $error("slave low undriven");
    chk_master_quiet: assert property (!m_txd |-> m_de) else $error("master low undriven");
    chk_slave_bit: assert property (s_txd != s_prev_r |-> s_run_r >= BIT_CYC - 1)
        else $error("slave bit short");
    chk_master_bit: assert property (m_txd != m_prev_r |-> m_run_r >= BIT_CYC - 1)
        else $error("master bit short");
    chk_reply_delay: assert property ($rose(s_de) |-> m_run_r >= GAP_CYC)
        else $error("reply too soon");
    chk_master_gap: assert property ($rose(m_de) |-> s_run_r >= GAP_CYC)
        else $error("request too soon");
    chk_slave_start: assert property ($rose(s_de) |-> ##[0:3] !s_txd)
        else $error("no start bit");
endmodule // mrsf_link_asserts

// ==== testbench/tb_modbus_rtu_slave_framer.sv ====
// Purpose: end-to-end bench of the rtu master and slave
// Assumes: short bit and gap counts, fetch answered next cycle
// Notes: register value is address xor 1289, group ee unmapped
`timescale 1ns/1ps
`define CMP(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_modbus_rtu_slave_framer;
    logic clk_sys = 1'b0, rstn = 1'b0, req_valid = 1'b0, rd_ack = 1'b0, rd_err = 1'b0;
    logic [7:0] station_id = 8'h05, req_addr = 8'h00, rd_group, rd_index, rx_byte;
    logic [7:0] got[$], exp[$];
    logic [15:0] req_reg = 16'h0000, req_cnt = 16'h0000, rd_data = 16'h0000;
    logic [23:0] cfg_gap_cyc = 24'h000000, cfg_dly_cyc = 24'h000000;
    logic rd_req, busy, rx_valid, done, resp_ok, resp_tmo, frm_ok, crc_err, s_prev = 1'b0;
    logic m_rstn = 1'b0; // master-only reset, lets a request be cut short
    int errors = 0, compares = 0, cyc = 0, last_m = 0, dly = 0, n_frm = 0, n_bad = 0;
    // short bit and gap keep the run small; all three ends share them
    localparam int BC = 16, GC = 600, TC = 4000;
    mrsf_link_if lnk();
    mrsf_master #(.BIT_CYC(BC), .GAP_CYC(GC), .TMO_CYC(TC)) u_mrsf_master (.bus(lnk),
        .rstn(m_rstn), .*);
    mrsf_slave #(.BIT_CYC(BC), .GAP_CYC(GC)) u_mrsf_slave (.bus(lnk), .*);
    mrsf_link_asserts #(.BIT_CYC(BC), .GAP_CYC(GC)) u_mrsf_link_asserts (.clk_sys(clk_sys),
        .rstn(rstn), .m_txd(lnk.m_txd), .m_de(lnk.m_de), .s_txd(lnk.s_txd), .s_de(lnk.s_de));
    // 25 ns period
    always #12.5 clk_sys = ~clk_sys;
    // fetch answered a cycle after it rises; ack drops so the next fetch is seen
    always @(posedge clk_sys) begin
        #1 rd_ack = rd_req & ~rd_ack;
        rd_data = {rd_group, rd_index} ^ 16'h1289;
        rd_err = (rd_group == 8'hee);
        cyc++;
        if (cyc == 100000) begin
            errors++;
            tally_and_finish();
        end
    end
    // outputs sampled mid-cycle, clear of the edge that moves them
    always @(negedge clk_sys) begin
        if (rx_valid) got.push_back(rx_byte);
        if (frm_ok) n_frm++;
        if (crc_err) n_bad++;
        if (lnk.m_de) last_m = cyc;
        if (lnk.s_de && !s_prev) dly = cyc - last_m;
        s_prev = lnk.s_de;
    end
    task automatic tally_and_finish();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // one request through the master; reply bytes collect in got
    task automatic xfer(input logic [7:0] a, input logic [15:0] r, input logic [15:0] n);
        int t;
        got.delete();
        {req_addr, req_reg, req_cnt, req_valid} = {a, r, n, 1'b1};
        @(posedge clk_sys);
        #1 req_valid = 1'b0;
        `CMP(busy, 1'b1)
        for (t = 0; t < 20000 && done !== 1'b1; t++) @(negedge clk_sys);
        if (t == 20000) errors++;
        @(posedge clk_sys);
        #1;
    endtask
    // builds the expected reply, checksum low byte first, then runs the read
    task automatic rd(input logic [15:0] r, input int n, input logic [7:0] ex);
        logic [15:0] c;
        if (ex != 8'h00) exp = {8'h05, 8'h83, ex};
        else exp = {8'h05, 8'h03, 8'(2 * n)};
        for (int i = 0; i < n && ex == 8'h00; i++) begin
            c = (r + 16'(i)) ^ 16'h1289;
            exp.push_back(c[15:8]);
            exp.push_back(c[7:0]);
        end
        c = 16'hffff;
        foreach (exp[i]) begin
            c = c ^ {8'h00, exp[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        exp.push_back(c[7:0]);
        exp.push_back(c[15:8]);
        xfer(8'h05, r, 16'(n));
        `CMP(got.size(), exp.size())
        foreach (exp[i]) `CMP(got[i], exp[i])
    endtask
    // every reply kind but the function-code exception, the two silent cases, then the delay table
    initial begin
        repeat (4) @(posedge clk_sys);
        #1 {rstn, m_rstn} = 2'b11;
        rd(16'h0101, 1, 8'h00);
        `CMP(got[5], 8'h44)
        `CMP(got[6], 8'hd2)
        `CMP(resp_ok, 1'b1)
        rd(16'h2a00, 10, 8'h00);
        rd(16'h0101, 0, 8'h05);
        rd(16'h0101, 11, 8'h05);
        rd(16'hee00, 1, 8'h04);
        xfer(8'h07, 16'h0101, 16'h0001);
        `CMP(resp_tmo, 1'b1)
        xfer(8'h00, 16'h0101, 16'h0001);
        `CMP(got.size(), 0)
        `CMP(n_frm, 6)
        // a new station number must be honoured at once
        station_id = 8'h07;
        xfer(8'h07, 16'h0101, 16'h0001);
        `CMP({resp_ok, got[0]}, 9'h107)
        station_id = 8'h05;
        // the larger of setting and minimum must win; the first row leaves both settings at zero, the other two each lift one
        for (int k = 0; k < 3; k++) begin
            {cfg_gap_cyc, cfg_dly_cyc} = (k == 2) ? {24'h0003e8, 24'h000000}
                : {24'h000000, 24'(k * 2000)};
            rd(16'h0101, 1, 8'h00);
            `CMP($unsigned(dly - (k == 1 ? 1984 : k == 2 ? 984 : 584)) < 120, 1'b1)
        end
        `CMP(n_bad, 0)
        // master reset inside the second byte, while its line is high, leaves a stub
        {req_addr, req_valid} = {8'h05, 1'b1};
        @(posedge clk_sys);
        #1 req_valid = 1'b0;
        wait (lnk.m_de);
        repeat (190) @(posedge clk_sys);
        #1 m_rstn = 1'b0;
        @(posedge clk_sys);
        #1 m_rstn = 1'b1;
        `CMP({busy, lnk.m_de, lnk.m_txd}, 3'b001)
        // the stub closes only after the configured gap of 1000 cycles
        repeat (1500) @(posedge clk_sys);
        #1;
        `CMP(n_bad, 1)
        `CMP(n_frm, 10)
        tally_and_finish();
    end
endmodule // tb_modbus_rtu_slave_framer
